// [inc/eepc_pkg.sv]
/*
 * eepc_pkg: constants, bus carrier and state types of the
 * nonvolatile array program/erase controller.
 * assumes a byte-wide cpu bus with a 16-bit address.
 */
`default_nettype none
package eepc_pkg;
    // ==========================================================
    // address map
    localparam logic [15:0] EEPC_CTRL_ADDR  = 16'h001C;
    localparam logic [15:0] EEPC_ARR_FIRST  = 16'h0400;
    localparam logic [15:0] EEPC_ARR_LAST   = 16'h04FF;
    localparam int          EEPC_ARR_BYTES  = 256;
    localparam int          EEPC_IDX_W      = 8;
    // block number sits in the top two bits of the array index
    localparam int          EEPC_BLK_HI     = 7;
    localparam int          EEPC_BLK_LO     = 6;

    // ==========================================================
    // control register layout
    localparam int          EEPC_B_PUMP     = 6;
    localparam int          EEPC_B_ERS_HI   = 4;
    localparam int          EEPC_B_ERS_LO   = 3;
    localparam int          EEPC_B_LATCH    = 2;
    localparam int          EEPC_B_RC       = 1;
    localparam int          EEPC_B_POWER    = 0;
    localparam logic [7:0]  EEPC_CTRL_RST   = 8'h00;

    // ==========================================================
    // data values
    localparam logic [7:0]  EEPC_ERASED     = 8'hFF;
    localparam logic [7:0]  EEPC_BLOCKED    = 8'h00;
    localparam logic [7:0]  EEPC_ZERO       = 8'h00;

    typedef enum logic [1:0] {
        EEPC_PROGRAM,
        EEPC_BYTE_ERASE,
        EEPC_BLOCK_ERASE,
        EEPC_BULK_ERASE
    } eepc_mode_e;

    // ==========================================================
    // bus request carrier
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } eepc_req_s;

    // whole state of the controller
    typedef struct packed {
        logic                                pump;
        eepc_mode_e                          mode;
        logic                                latch;
        logic                                rc;
        logic                                power;
        logic                                captured;
        logic [EEPC_IDX_W-1:0]               cap_addr;
        logic [7:0]                          cap_data;
        logic [7:0]                          rdata;
        logic [EEPC_ARR_BYTES-1:0][7:0]      mem;
    } eepc_state_s;
endpackage
`default_nettype wire

// [rtl/eepc_rst_sync.sv]
/*
 * eepc_rst_sync: two-stage release of the active-low reset.
 * assumes i_rst_n may change at any time; release is clocked.
 */
`timescale 1ns/1ps
`default_nettype none
module eepc_rst_sync (
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    output var  logic o_rst_n
);
    // ==========================================================
    // synchroniser, assert async, release after two edges
    logic meta_q;
    logic sync_q;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            sync_q <= meta_q;
        end
    end

    assign o_rst_n = sync_q;
endmodule // eepc_rst_sync
`default_nettype wire

// [rtl/eepc_ctrl.sv]
/*
 * eepc_ctrl: program/erase controller with its 256-byte array
 * held in flip-flops and one control register on the cpu bus.
 * assumes single-cycle strobes, read data one cycle later, and
 * software that times every power pulse itself.
 */
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R1] pump bit enables charge pump, reset zero
// [R2] two-bit field selects program or erase mode
// [R3] byte erase clears only the addressed byte
// [R4] block erase clears aligned 64-byte block
// [R5] bulk erase clears the whole array
// [R6] latch bit captures array writes for programming
// [R7] array reads blocked once latched write captured
// [R8] rc bit picks array clock source
// [R9] power bit drives pump and array power
// [R10] power bit writable only while latched
// [R11] no array power until power bit set
// [R12] program: latch, pump, mode 00, write, pulse
// [R13] erase: latch, pump, mode, write, pulse
// [R14] end: drop power, wait, clear latch, pump
// [R15] erased reads ones; programming only clears bits
// [R16] array lives at 0x0400 through 0x04FF
// [R17] power lasts exactly while software holds it
module eepc_ctrl
    import eepc_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire eepc_req_s  i_req,
    output var  logic [7:0] o_rdata,
    output var  logic       o_pump_on,
    output var  logic       o_prog_power,
    output var  logic       o_rc_clock_select,
    output var  logic       o_bus_latched,
    output var  logic [1:0] o_erase_mode
);
    // ==========================================================
    // reset release
    logic rst_n;

    eepc_rst_sync u_rst_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .o_rst_n    (rst_n)
    );

    // ==========================================================
    // address decode
    logic                  hit_ctrl;
    logic                  hit_arr;
    logic [EEPC_IDX_W-1:0] arr_idx;

    always_comb begin
        hit_ctrl = 1'b0;
        hit_arr  = 1'b0;
        if (i_req.addr == EEPC_CTRL_ADDR) begin
            hit_ctrl = 1'b1;
        end else if (i_req.addr >= EEPC_ARR_FIRST &&
                     i_req.addr <= EEPC_ARR_LAST) begin
            hit_arr = 1'b1; // see [R16]
        end
    end

    // window is aligned, so the low byte is the index
    assign arr_idx = i_req.addr[EEPC_IDX_W-1:0];

    // ==========================================================
    // state
    eepc_state_s s_q;
    eepc_state_s s_d;
    logic [7:0]  ctrl_view;

    always_comb begin
        ctrl_view                = EEPC_ZERO;
        ctrl_view[EEPC_B_PUMP]   = s_q.pump;
        ctrl_view[EEPC_B_ERS_HI] = s_q.mode[1];
        ctrl_view[EEPC_B_ERS_LO] = s_q.mode[0];
        ctrl_view[EEPC_B_LATCH]  = s_q.latch;
        ctrl_view[EEPC_B_RC]     = s_q.rc;
        ctrl_view[EEPC_B_POWER]  = s_q.power;
    end

    always_comb begin
        s_d       = s_q;
        // read data stand for one cycle only
        s_d.rdata = EEPC_ZERO;

        // ------------------------------------------------------
        // register and array reads
        if (i_req.rd && hit_ctrl) begin
            s_d.rdata = ctrl_view;
        end else if (i_req.rd && hit_arr) begin
            if (s_q.latch && s_q.captured) begin
                s_d.rdata = EEPC_BLOCKED; // see [R7]
            end else begin
                s_d.rdata = s_q.mem[arr_idx];
            end
        end

        // ------------------------------------------------------
        // control register write
        if (i_req.wr && hit_ctrl) begin
            s_d.pump  = i_req.wdata[EEPC_B_PUMP]; // see [R1]
            s_d.mode  = eepc_mode_e'({i_req.wdata[EEPC_B_ERS_HI],
                                      i_req.wdata[EEPC_B_ERS_LO]});
            s_d.latch = i_req.wdata[EEPC_B_LATCH];
            s_d.rc    = i_req.wdata[EEPC_B_RC]; // see [R8]
            // power changes only under the latch held beforehand
            if (s_q.latch) begin
                s_d.power = i_req.wdata[EEPC_B_POWER]; // see [R10]
            end
        end

        // dropping the latch releases the captured address
        if (!s_d.latch) begin
            s_d.captured = 1'b0;
        end

        // ------------------------------------------------------
        // array write: captured under latch, ignored otherwise
        if (i_req.wr && hit_arr && s_q.latch) begin
            s_d.captured = 1'b1; // see [R6]
            s_d.cap_addr = arr_idx;
            s_d.cap_data = i_req.wdata;
        end

        // ------------------------------------------------------
        // array power: acts every cycle the bit is held with a write captured, so the
        // pulse length is software's alone; repeating is harmless
        if (s_q.power && s_q.captured) begin // see [R11] see [R17]
            case (s_q.mode)
                EEPC_PROGRAM: begin
                    s_d.mem[s_q.cap_addr] = s_q.mem[s_q.cap_addr] &
                                            s_q.cap_data; // see [R15]
                end
                EEPC_BYTE_ERASE: begin
                    s_d.mem[s_q.cap_addr] = EEPC_ERASED; // see [R3]
                end
                EEPC_BLOCK_ERASE: begin
                    for (int i = 0; i < EEPC_ARR_BYTES; i++) begin
                        if (EEPC_IDX_W'(i) >> EEPC_BLK_LO ==
                            s_q.cap_addr >> EEPC_BLK_LO) begin
                            s_d.mem[i] = EEPC_ERASED; // see [R4]
                        end
                    end
                end
                default: begin
                    for (int i = 0; i < EEPC_ARR_BYTES; i++) begin
                        s_d.mem[i] = EEPC_ERASED; // see [R5]
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // registers; array comes up erased, control all clear
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.pump     <= EEPC_CTRL_RST[EEPC_B_PUMP];
            s_q.mode     <= EEPC_PROGRAM; // see [R2]
            s_q.latch    <= EEPC_CTRL_RST[EEPC_B_LATCH];
            s_q.rc       <= EEPC_CTRL_RST[EEPC_B_RC];
            s_q.power    <= EEPC_CTRL_RST[EEPC_B_POWER];
            s_q.captured <= 1'b0;
            s_q.cap_addr <= EEPC_ZERO;
            s_q.cap_data <= EEPC_ZERO;
            s_q.rdata    <= EEPC_ZERO;
            s_q.mem      <= {EEPC_ARR_BYTES{EEPC_ERASED}};
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign o_rdata           = s_q.rdata;
    assign o_pump_on         = s_q.pump | s_q.power; // see [R9]
    assign o_prog_power      = s_q.power; // see [R9]
    assign o_rc_clock_select = s_q.rc; // see [R8]
    assign o_bus_latched     = s_q.latch; // see [R6]
    assign o_erase_mode      = s_q.mode; // see [R2]

    // ==========================================================
    // checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_armed;
        s_q.power && s_q.captured;
    endsequence

    sequence s_ctrl_wr;
        i_req.wr && hit_ctrl;
    endsequence

    property p_pump_out;
        s_ctrl_wr |=> o_pump_on ==
            ($past(i_req.wdata[EEPC_B_PUMP]) || o_prog_power);
    endproperty
    a_pump_out: assert property (p_pump_out) // see [R1] see [R9]
        else $error("pump output does not follow pump or power");

    property p_mode_wr;
        s_ctrl_wr |=> o_erase_mode ==
            {$past(i_req.wdata[EEPC_B_ERS_HI]),
             $past(i_req.wdata[EEPC_B_ERS_LO])};
    endproperty
    a_mode_wr: assert property (p_mode_wr) // see [R2]
        else $error("erase mode not taken from write");

    property p_power_locked;
        s_ctrl_wr ##0 (!s_q.latch && !s_q.power) |=> !o_prog_power;
    endproperty
    a_power_locked: assert property (p_power_locked) // see [R10]
        else $error("power set without latch");

    property p_capture;
        i_req.wr && hit_arr && s_q.latch |=>
            s_q.captured && s_q.cap_addr == $past(arr_idx) &&
            s_q.cap_data == $past(i_req.wdata);
    endproperty
    a_capture: assert property (p_capture) // see [R6]
        else $error("array write under latch not captured");

    property p_read_block;
        i_req.rd && hit_arr && s_q.latch && s_q.captured |=>
            o_rdata == EEPC_BLOCKED;
    endproperty
    a_read_block: assert property (p_read_block) // see [R7]
        else $error("array read not blocked");

    property p_prog_clears_only;
        s_armed ##0 (s_q.mode == EEPC_PROGRAM) |=>
            s_q.mem[$past(s_q.cap_addr)] ==
            ($past(s_q.mem[s_q.cap_addr]) & $past(s_q.cap_data));
    endproperty
    a_prog_clears_only: assert property (p_prog_clears_only) // see [R15]
        else $error("programming did not and in data");

    property p_byte_erase;
        s_armed ##0 (s_q.mode == EEPC_BYTE_ERASE) |=>
            s_q.mem[$past(s_q.cap_addr)] == EEPC_ERASED &&
            s_q.mem[$past(s_q.cap_addr) ^ 8'h01] ==
            $past(s_q.mem[s_q.cap_addr ^ 8'h01]);
    endproperty
    a_byte_erase: assert property (p_byte_erase) // see [R3]
        else $error("byte erase wrong extent");

    property p_block_erase;
        s_armed ##0 (s_q.mode == EEPC_BLOCK_ERASE) |=>
            s_q.mem[$past(s_q.cap_addr) | 8'h3F] == EEPC_ERASED &&
            s_q.mem[$past(s_q.cap_addr) & 8'hC0] == EEPC_ERASED &&
            s_q.mem[$past(s_q.cap_addr) ^ 8'h40] ==
            $past(s_q.mem[s_q.cap_addr ^ 8'h40]);
    endproperty
    a_block_erase: assert property (p_block_erase) // see [R4]
        else $error("block erase wrong extent");

    property p_bulk_erase;
        s_armed ##0 (s_q.mode == EEPC_BULK_ERASE) |=>
            s_q.mem == {EEPC_ARR_BYTES{EEPC_ERASED}};
    endproperty
    a_bulk_erase: assert property (p_bulk_erase) // see [R5]
        else $error("bulk erase left bytes");

    property p_no_power_no_change;
        !s_q.power |=> s_q.mem == $past(s_q.mem);
    endproperty
    a_no_power_no_change: assert property (p_no_power_no_change) // see [R11]
        else $error("array changed without power");

    property p_power_held;
        s_ctrl_wr ##0 !i_req.wdata[EEPC_B_POWER] ##0 s_q.latch |=>
            !o_prog_power;
    endproperty
    a_power_held: assert property (p_power_held) // see [R17]
        else $error("power outlived its bit");

    property p_rc_sel;
        s_ctrl_wr |=> o_rc_clock_select ==
            $past(i_req.wdata[EEPC_B_RC]);
    endproperty
    a_rc_sel: assert property (p_rc_sel) // see [R8]
        else $error("rc select not taken");

    // ==========================================================
    // bus side: read data, unmapped space, held fields
    property p_rdata_idle;
        !i_req.rd |=> o_rdata == EEPC_ZERO;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outlived its cycle");

    property p_unmapped_read;
        i_req.rd && !hit_ctrl && !hit_arr |=> o_rdata == EEPC_ZERO;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) // see [R16]
        else $error("unmapped read returned data");

    property p_arr_read;
        i_req.rd && hit_arr && !(s_q.latch && s_q.captured) |=>
            o_rdata == $past(s_q.mem[arr_idx]);
    endproperty
    a_arr_read: assert property (p_arr_read) // see [R16]
        else $error("array read returned wrong byte");

    property p_fields_held;
        !(i_req.wr && hit_ctrl) |=> $stable(o_erase_mode) &&
            $stable(o_bus_latched) && $stable(o_rc_clock_select);
    endproperty
    a_fields_held: assert property (p_fields_held) // see [R2]
        else $error("control field moved without a write");

    // ==========================================================
    // capture and power sequencing
    property p_unlatched_wr;
        i_req.wr && hit_arr && !s_q.latch |=> !s_q.captured &&
            s_q.cap_addr == $past(s_q.cap_addr) &&
            s_q.cap_data == $past(s_q.cap_data);
    endproperty
    a_unlatched_wr: assert property (p_unlatched_wr) // see [R6]
        else $error("array write captured without latch");

    property p_latch_drop;
        s_ctrl_wr ##0 !i_req.wdata[EEPC_B_LATCH] |=> !s_q.captured;
    endproperty
    a_latch_drop: assert property (p_latch_drop) // see [R6]
        else $error("capture kept after latch cleared");

    property p_power_rise;
        $rose(o_prog_power) |-> $past(s_q.latch);
    endproperty
    a_power_rise: assert property (p_power_rise) // see [R10]
        else $error("power rose without latch");

    // no internal timer: the bit stays until software clears it
    property p_power_stays;
        o_prog_power && !(i_req.wr && hit_ctrl) |=> o_prog_power;
    endproperty
    a_power_stays: assert property (p_power_stays) // see [R17]
        else $error("power pulse ended on its own");

    property p_power_pump;
        o_prog_power |-> o_pump_on;
    endproperty
    a_power_pump: assert property (p_power_pump) // see [R9]
        else $error("power on without pump");

endmodule // eepc_ctrl
`default_nettype wire

// [tb/eepc_cpu_model.sv]
/*
 * eepc_cpu_model: cpu-side bus master with write and read tasks.
 * assumes single-cycle strobes and read data one cycle after rd.
 */
`timescale 1ns/1ps
`default_nettype none
module eepc_cpu_model
    import eepc_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rdata,
    output var  eepc_req_s  o_req
);
    // ==========================================================
    // bus cycles
    initial o_req = '0;

    // strobe released at the edge that takes it, never later
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        o_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_core_clk);
        o_req <= '0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        o_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_core_clk);
        o_req <= '0;
        #1;
        d = i_rdata;
    endtask
endmodule // eepc_cpu_model
`default_nettype wire

// [tb/eepc_ctrl_bench.sv]
/*
 * eepc_ctrl_bench: register-level tests of the program/erase block.
 * assumes the cpu model drives all bus cycles; no random stimulus.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin \
    miscompares++; $display("Error t=%0t got %h exp %h", \
    $time, (a), (b)); end end
module eepc_ctrl_bench
    import eepc_pkg::*;
();
    logic       clk;
    logic       rst_n;
    eepc_req_s  req;
    logic [7:0] rdata;
    logic       pump_on;
    logic       power;
    logic       rc_sel;
    logic       latched;
    logic [1:0] mode;
    logic [7:0] v;
    int         miscompares = 0;
    int         n_tests = 0;

    eepc_ctrl dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_req(req),
        .o_rdata(rdata), .o_pump_on(pump_on), .o_prog_power(power),
        .o_rc_clock_select(rc_sel), .o_bus_latched(latched),
        .o_erase_mode(mode));
    eepc_cpu_model cpu_u (.i_core_clk(clk), .i_rdata(rdata),
        .o_req(req));

    // ==========================================================
    // clock, reset, verdict
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic end_sim();
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // whole run is a few hundred cycles; 3000 leaves ample margin
    initial begin
        #(3000 * 100);
        miscompares++;
        end_sim();
    end

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        cpu_u.rd(a, v);
        `CHK(v, e)
    endtask

    // full sequence: latch+pump+mode, capture, pulse, drop, clear
    task automatic run_op(input logic [1:0] m, input logic [15:0] a,
                          input logic [7:0] d);
        cpu_u.wr(EEPC_CTRL_ADDR, 8'h44 | {3'b000, m, 3'b000});
        `CHK(latched, 1'b1)
        cpu_u.wr(a, d);
        rd_chk(a, EEPC_BLOCKED);
        cpu_u.wr(EEPC_CTRL_ADDR, 8'h45 | {3'b000, m, 3'b000});
        `CHK({pump_on, power}, 2'b11)
        repeat (5) @(posedge clk);
        #1;
        `CHK(power, 1'b1)
        cpu_u.wr(EEPC_CTRL_ADDR, 8'h44 | {3'b000, m, 3'b000});
        `CHK(power, 1'b0)
        cpu_u.wr(EEPC_CTRL_ADDR, 8'h00);
    endtask

    // ==========================================================
    // tests
    initial begin
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHK({pump_on, power, rc_sel, latched, mode}, 6'h00)
        rd_chk(EEPC_CTRL_ADDR, EEPC_CTRL_RST);
        rd_chk(16'h0400, EEPC_ERASED);
        rd_chk(16'h0000, 8'h00);
        rd_chk(16'h03FF, 8'h00);
        rd_chk(16'h0500, 8'h00);
        // power write refused while latch still clear
        cpu_u.wr(EEPC_CTRL_ADDR, 8'h5F);
        `CHK({pump_on, power, rc_sel, latched}, 4'hB)
        `CHK(mode, 2'b11)
        rd_chk(EEPC_CTRL_ADDR, 8'h5E);
        cpu_u.wr(EEPC_CTRL_ADDR, 8'h00);
        `CHK({pump_on, rc_sel}, 2'b00)
        // array write without latch is ignored
        cpu_u.wr(16'h0420, 8'h00);
        rd_chk(16'h0420, EEPC_ERASED);
        // power alone runs the pump; a capture without power is inert
        cpu_u.wr(EEPC_CTRL_ADDR, 8'h04);
        cpu_u.wr(EEPC_CTRL_ADDR, 8'h05);
        `CHK({pump_on, power}, 2'b11)
        cpu_u.wr(EEPC_CTRL_ADDR, 8'h04);
        `CHK({pump_on, power}, 2'b00)
        cpu_u.wr(16'h0420, 8'h00);
        cpu_u.wr(EEPC_CTRL_ADDR, 8'h00);
        rd_chk(16'h0420, EEPC_ERASED);
        // program clears only zero bits, a second pass ands
        run_op(2'b00, 16'h0410, 8'hA5);
        rd_chk(16'h0410, 8'hA5);
        run_op(2'b00, 16'h0410, 8'h3C);
        rd_chk(16'h0410, 8'h24);
        run_op(2'b00, 16'h0411, 8'h00);
        run_op(2'b00, 16'h0450, 8'h00);
        run_op(2'b00, 16'h04FF, 8'h00);
        run_op(2'b00, 16'h04C0, 8'h00);
        run_op(2'b01, 16'h0410, 8'h77);
        rd_chk(16'h0410, EEPC_ERASED);
        rd_chk(16'h0411, 8'h00);
        run_op(2'b10, 16'h0405, 8'h00);
        rd_chk(16'h0411, EEPC_ERASED);
        rd_chk(16'h0450, 8'h00);
        run_op(2'b10, 16'h04FE, 8'h00);
        rd_chk(16'h04C0, EEPC_ERASED);
        rd_chk(16'h0450, 8'h00);
        run_op(2'b11, 16'h0433, 8'h12);
        rd_chk(16'h0450, EEPC_ERASED);
        rd_chk(16'h0433, EEPC_ERASED);
        rd_chk(EEPC_CTRL_ADDR, 8'h00);
        end_sim();
    end
endmodule // eepc_ctrl_bench
`default_nettype wire
